// ==== hw/osf_formatter.sv ====
// Sector formatter: header and data field writer, header reader
// Contract
// [RULE1] 512 sector: 512 user, 12 pointer, two FF, 4 CRC, 80 ECC
// [RULE2] 512 sector: resync after every 15 info bytes, 40 total
// [RULE3] 1024 sector: 1024 user, 12 pointer, 4 CRC, 160 ECC
// [RULE4] 1024 sector: resync after every 20 info bytes, 59 total
// [RULE5] Data area order: VFO, sync, user, pointer, CRC, ECC
// [RULE6] Everything is run-length coded except raw mark patterns; the code also writes the VFO and flag fields raw
// [RULE7] Fixed (2,7) group table for encoding; inverse for decoding
// [RULE8] Header of 52 bytes: mark, VFOs, address marks, IDs, postamble
// [RULE9] Three ID copies differ only in two copy bits of sector byte
// [RULE10] Sector mark detect ignores the optional x bit
// [RULE11] Header VFOs 12 or 8 bytes; second closes prior CRC code
// [RULE12] ID field found by raw address mark 4804 hex
// [RULE13] ID field: two track bytes, sector byte, two CRC bytes
// [RULE14] ID CRC 1021 polynomial, preset ones, MSB first
// [RULE15] Header postamble byte closes final CRC byte encoding
// [RULE16] Optional flag field written in the data-field pass
// [RULE17] Flag field is five bytes of 3T pattern from 1001
// [RULE18] Resync mark is raw 2024 hex, closing the byte before
// [RULE19] Data VFO is 12 bytes of the first VFO pattern
// [RULE20] Data postamble written with resync pattern
// [RULE21] ECC bytes inverted with FF, CRC bytes not inverted
// [RULE22] ECC bytes pass in source order, interleaves round-robin
// [RULE23] One byte per step; counters restart at data sync mark
`timescale 1ns/1ps
module osf_formatter import osf_pkg::*; #(
  parameter logic [15:0] SYNC_PAT0 = 16'h0000,
  parameter logic [15:0] SYNC_PAT1 = 16'h0000,
  parameter logic [15:0] SYNC_PAT2 = 16'h0000,
  parameter logic SECTOR_MARK_X = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic hdr_start_i,
  input wire logic [15:0] hdr_track_i,
  input wire logic [5:0] hdr_sector_i,
  input wire logic data_start_i,
  input wire logic size_1k_i,
  input wire logic flag_en_i,
  input wire logic [7:0] src_data_i,
  input wire logic src_valid_i,
  output logic src_ready_o,
  output logic busy_o,
  output logic chan_bit_o,
  output logic chan_valid_o,
  input wire logic rx_bit_i,
  input wire logic rx_valid_i,
  output logic sector_mark_o,
  output logic id_found_o,
  output logic [15:0] id_track_o,
  output logic [5:0] id_sector_o,
  output logic [1:0] id_copy_o,
  output logic id_crc_ok_o
);

  typedef enum logic [3:0] {
    OSF_IDLE, OSF_H_SM, OSF_H_FIRST_LOCK_PREAMBLE, OSF_H_AM, OSF_H_ID, OSF_H_SECOND_LOCK_PREAMBLE,
    OSF_H_PA, OSF_D_FLAG, OSF_D_VFO, OSF_D_SYNC, OSF_D_INFO,
    OSF_D_RESYNC, OSF_D_PA
  } osf_state_e;

  // 3T word for a phase
  function automatic logic [15:0] t3_word(input logic [1:0] ph);
    case (ph)
      2'h1: return T3_PH1;
      2'h2: return T3_PH2;
      default: return T3_PH0;
    endcase
  endfunction : t3_word

  // Channel code to NRZ group; prefix-free, checked at even lengths
  function automatic osf_dec_s rll_dec(input logic [7:0] cw,
                                       input logic [3:0] n);
    osf_dec_s d;
    d = '{hit: 1'b0, nlen: 3'h0, bits: 4'h0};
    if (n == 4'h4 && cw[3:0] == 4'b0100) d = '{1'b1, 3'h2, 4'b0010};
    if (n == 4'h4 && cw[3:0] == 4'b1000) d = '{1'b1, 3'h2, 4'b0011};
    if (n == 4'h6 && cw[5:0] == 6'b000100) d = '{1'b1, 3'h3, 4'b0000};
    if (n == 4'h6 && cw[5:0] == 6'b100100) d = '{1'b1, 3'h3, 4'b0010};
    if (n == 4'h6 && cw[5:0] == 6'b001000) d = '{1'b1, 3'h3, 4'b0011};
    if (n == 4'h8 && cw == 8'b00100100) d = '{1'b1, 3'h4, 4'b0010};
    if (n == 4'h8 && cw == 8'b00001000) d = '{1'b1, 3'h4, 4'b0011};
    return d;
  endfunction : rll_dec

  osf_state_e st_reg, st_next;
  logic [10:0] cnt_reg, cnt_next;
  logic [10:0] info_reg, info_next;
  logic [4:0] rs_reg, rs_next;
  logic [1:0] copy_reg, copy_next;
  logic size_1k_reg;
  logic [15:0] track_reg;
  logic [5:0] sector_reg;
  osf_sym_s sym;
  logic sym_valid, sym_ready, enc_idle;
  logic need_src;
  logic [10:0] field_len;
  logic [1:0] ph_start;

  // Data field region boundaries per sector size
  wire [10:0] usr_cp_end = size_1k_reg ? 11'(USER_1K + CP_BYTES) :
                           11'(USER_512 + CP_BYTES); // [RULE1] [RULE3]
  wire [10:0] rsv_end = usr_cp_end + (size_1k_reg ? 11'(RSV_1K) :
                        11'(RSV_512));
  wire [10:0] crc_end = rsv_end + 11'(CRC_BYTES);
  wire [10:0] total = crc_end + (size_1k_reg ? 11'(ECC_1K) :
                      11'(ECC_512));
  wire [4:0] rs_int = size_1k_reg ? 5'(RS_INT_1K) : 5'(RS_INT_512);
  wire in_rsv = info_reg >= usr_cp_end && info_reg < rsv_end;
  wire in_ecc = info_reg >= crc_end;

  // ID bytes with copy bits and CRC for the current copy
  wire [7:0] sect_byte = {copy_reg, sector_reg}; // [RULE9]
  wire [15:0] id_crc = osf_crc16(osf_crc16(osf_crc16(ID_CRC_INIT,
                       track_reg[15:8]), track_reg[7:0]),
                       sect_byte); // [RULE14]
  wire [7:0] id_byte = (cnt_reg == 11'h000) ? track_reg[15:8] :
                       (cnt_reg == 11'h001) ? track_reg[7:0] :
                       (cnt_reg == 11'h002) ? sect_byte :
                       (cnt_reg == 11'h003) ? id_crc[15:8] :
                       id_crc[7:0]; // [RULE13]
  wire [1:0] t3_ph = 2'((cnt_reg + 11'(ph_start)) % 11'h003);
  wire [7:0] sm_tail = SECTOR_MARK_PAT[7:0] |
                       (8'(SECTOR_MARK_X) << SECTOR_MARK_X_BIT);
  wire [15:0] sync_pat = (cnt_reg == 11'h000) ? SYNC_PAT0 :
                         (cnt_reg == 11'h001) ? SYNC_PAT1 : SYNC_PAT2;
  wire [7:0] info_byte = in_rsv ? RSV_VAL :
                         in_ecc ? (src_data_i ^ ECC_INV) :
                         src_data_i; // [RULE21] [RULE22]

  // Symbol generated for the current field and byte
  always_comb begin
    sym = '{pat: 16'h0000, len: RAW_FULL_LEN, raw: 1'b1, last: 1'b0};
    need_src = 1'b0;
    field_len = 11'h001;
    ph_start = 2'h0;
    case (st_reg)
      OSF_H_SM: begin
        field_len = 11'(SECTOR_MARK_CHUNKS);
        if (cnt_reg == 11'h000) sym.pat = SECTOR_MARK_PAT[39:24];
        else if (cnt_reg == 11'h001) sym.pat = SECTOR_MARK_PAT[23:8];
        else begin
          sym.pat = {sm_tail, 8'h00};
          sym.len = RAW_HALF_LEN;
        end
      end
      OSF_H_FIRST_LOCK_PREAMBLE: begin
        field_len = 11'(FIRST_VFO_BYTES); // [RULE11]
        sym.pat = t3_word(t3_ph);
      end
      OSF_H_AM: sym.pat = ADDR_MARK_PAT; // [RULE12]
      OSF_H_ID: begin
        field_len = 11'(ID_BYTES);
        sym.raw = 1'b0;
        sym.pat = {8'h00, id_byte};
      end
      OSF_H_SECOND_LOCK_PREAMBLE: begin
        field_len = 11'(SECOND_VFO_BYTES); // [RULE11]
        ph_start = 2'h1;
        sym.pat = t3_word(t3_ph);
      end
      OSF_H_PA: begin
        sym.raw = 1'b0;
        sym.last = 1'b1; // [RULE15]
        sym.pat = {8'h00, HDR_POSTAMBLE_VAL};
      end
      OSF_D_FLAG: begin
        field_len = 11'(FLAG_BYTES); // [RULE17]
        ph_start = 2'h1;
        sym.pat = t3_word(t3_ph);
      end
      OSF_D_VFO: begin
        field_len = 11'(DATA_VFO_BYTES); // [RULE19]
        sym.pat = t3_word(t3_ph);
      end
      OSF_D_SYNC: begin
        field_len = 11'(SYNC_BYTES);
        sym.pat = sync_pat;
      end
      OSF_D_INFO: begin
        sym.raw = 1'b0;
        sym.pat = {8'h00, info_byte};
        need_src = !in_rsv;
      end
      OSF_D_RESYNC: sym.pat = RESYNC_PAT; // [RULE18]
      OSF_D_PA: sym.pat = RESYNC_PAT; // [RULE20]
      default: sym.pat = 16'h0000;
    endcase
  end

  // Handshake toward source and encoder
  assign sym_valid = st_reg != OSF_IDLE && (!need_src || src_valid_i);
  assign src_ready_o = need_src && sym_ready && src_valid_i;
  wire advance = sym_valid && sym_ready; // [RULE23]
  wire field_done = advance && cnt_reg == field_len - 11'h001;
  wire info_last = info_reg == total - 11'h001;
  wire rs_due = rs_reg == rs_int - 5'h01; // [RULE2] [RULE4]
  assign busy_o = st_reg != OSF_IDLE || !enc_idle;

  // Field sequencer
  always_comb begin
    st_next = st_reg;
    cnt_next = advance ? cnt_reg + 11'h001 : cnt_reg;
    info_next = info_reg;
    rs_next = rs_reg;
    copy_next = copy_reg;
    case (st_reg)
      OSF_IDLE: begin
        cnt_next = 11'h000;
        copy_next = 2'h0;
        if (hdr_start_i) st_next = OSF_H_SM; // [RULE8]
        else if (data_start_i) st_next = flag_en_i ? OSF_D_FLAG :
                                         OSF_D_VFO; // [RULE16]
      end
      OSF_H_SM: if (field_done) st_next = OSF_H_FIRST_LOCK_PREAMBLE;
      OSF_H_FIRST_LOCK_PREAMBLE: if (field_done) st_next = OSF_H_AM;
      OSF_H_SECOND_LOCK_PREAMBLE: if (field_done) st_next = OSF_H_AM;
      OSF_H_AM: if (field_done) st_next = OSF_H_ID;
      OSF_H_ID: begin
        if (field_done && copy_reg == 2'(ID_COPIES - 1)) begin
          st_next = OSF_H_PA;
        end else if (field_done) begin
          st_next = OSF_H_SECOND_LOCK_PREAMBLE;
          copy_next = copy_reg + 2'h1;
        end
      end
      OSF_H_PA: if (field_done) st_next = OSF_IDLE;
      OSF_D_FLAG: if (field_done) st_next = OSF_D_VFO;
      OSF_D_VFO: if (field_done) st_next = OSF_D_SYNC; // [RULE5]
      OSF_D_SYNC: begin
        info_next = 11'h000; // [RULE23]
        rs_next = 5'h00;
        if (field_done) st_next = OSF_D_INFO;
      end
      OSF_D_INFO: begin
        cnt_next = 11'h000;
        if (advance) begin
          info_next = info_reg + 11'h001; // [RULE1] [RULE3] [RULE5]
          rs_next = rs_due ? 5'h00 : rs_reg + 5'h01;
          if (info_last) st_next = OSF_D_PA;
          else if (rs_due) st_next = OSF_D_RESYNC; // [RULE2] [RULE4]
        end
      end
      OSF_D_RESYNC: begin
        cnt_next = 11'h000;
        if (advance) st_next = OSF_D_INFO;
      end
      OSF_D_PA: if (field_done) st_next = OSF_IDLE;
      default: st_next = OSF_IDLE;
    endcase
    if (field_done && st_reg != OSF_D_INFO) cnt_next = 11'h000;
  end

  // Sequencer registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= OSF_IDLE;
      cnt_reg <= 11'h000;
      info_reg <= 11'h000;
      rs_reg <= 5'h00;
      copy_reg <= 2'h0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      info_reg <= info_next;
      rs_reg <= rs_next;
      copy_reg <= copy_next;
    end
  end

  // Command operands captured on start
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      size_1k_reg <= 1'b0;
      track_reg <= 16'h0000;
      sector_reg <= 6'h00;
    end else if (st_reg == OSF_IDLE) begin
      size_1k_reg <= size_1k_i;
      track_reg <= hdr_track_i;
      sector_reg <= hdr_sector_i;
    end
  end

  // Channel encoder
  osf_rll_enc u_enc (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .sym_i(sym),
    .sym_valid_i(sym_valid),
    .sym_ready_o(sym_ready),
    .chan_bit_o(chan_bit_o),
    .chan_valid_o(chan_valid_o),
    .idle_o(enc_idle)
  );

  // Read side: mark detection and ID field decoding
  logic [39:0] win_reg;
  logic [7:0] cw_reg;
  logic [3:0] cw_cnt_reg;
  logic [47:0] id_sr_reg;
  logic [5:0] id_cnt_reg;
  logic rd_act_reg;
  wire [39:0] win = {win_reg[38:0], rx_bit_i};
  wire sm_hit = rx_valid_i && ((win & SECTOR_MARK_MASK) ==
                (SECTOR_MARK_PAT & SECTOR_MARK_MASK)); // [RULE10]
  wire am_hit = rx_valid_i && win[15:0] == ADDR_MARK_PAT; // [RULE12]
  wire [7:0] cw_new = {cw_reg[6:0], rx_bit_i};
  wire [3:0] cw_cnt_new = cw_cnt_reg + 4'h1;
  wire osf_dec_s dec = rll_dec(cw_new, cw_cnt_new); // [RULE7]
  wire dec_step = rd_act_reg && rx_valid_i && !am_hit;
  wire [47:0] id_sr_new = (id_sr_reg << dec.nlen) | 48'(dec.bits);
  wire [5:0] id_cnt_new = id_cnt_reg + 6'(dec.nlen);
  wire id_full = dec_step && dec.hit && id_cnt_new >= 6'h28;
  wire [39:0] id_bits = 40'(id_sr_new >> (id_cnt_new - 6'h28));
  wire [15:0] rd_res = osf_crc16(osf_crc16(osf_crc16(osf_crc16(
                       osf_crc16(ID_CRC_INIT, id_bits[39:32]),
                       id_bits[31:24]), id_bits[23:16]), id_bits[15:8]),
                       id_bits[7:0]); // [RULE14]

  // Channel window and group decoder state
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      win_reg <= 40'h0000000000;
      cw_reg <= 8'h00;
      cw_cnt_reg <= 4'h0;
      id_sr_reg <= 48'h000000000000;
      id_cnt_reg <= 6'h00;
      rd_act_reg <= 1'b0;
    end else begin
      if (rx_valid_i) win_reg <= win;
      if (am_hit) begin
        rd_act_reg <= 1'b1;
        cw_cnt_reg <= 4'h0;
        id_cnt_reg <= 6'h00;
        id_sr_reg <= 48'h000000000000;
      end else if (dec_step && dec.hit) begin
        cw_cnt_reg <= 4'h0;
        id_sr_reg <= id_sr_new;
        id_cnt_reg <= id_cnt_new;
        if (id_full) rd_act_reg <= 1'b0;
      end else if (dec_step) begin
        cw_reg <= cw_new;
        cw_cnt_reg <= cw_cnt_new;
        if (cw_cnt_new == 4'h8) rd_act_reg <= 1'b0; // Illegal code
      end
    end
  end

  // Read results: mark and ID found are one-cycle pulses, ID fields held until the next ID field
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sector_mark_o <= 1'b0;
      id_found_o <= 1'b0;
      id_track_o <= 16'h0000;
      id_sector_o <= 6'h00;
      id_copy_o <= 2'h0;
      id_crc_ok_o <= 1'b0;
    end else begin
      sector_mark_o <= sm_hit;
      id_found_o <= id_full;
      if (id_full) begin
        id_track_o <= id_bits[39:24]; // [RULE13]
        id_sector_o <= id_bits[21:16];
        id_copy_o <= id_bits[16 + ID_COPY_LSB +: 2]; // [RULE9]
        id_crc_ok_o <= rd_res == 16'h0000;
      end
    end
  end

endmodule : osf_formatter

// ==== hw/osf_pkg.sv ====
// Shared constants, carriers and CRC helper for the optical sector formatter
package osf_pkg;

  // One symbol toward the channel encoder: raw pattern or NRZ byte
  typedef struct packed {
    logic [15:0] pat;  // Raw pattern, MSB first; NRZ byte in [7:0]
    logic [4:0] len;   // Raw pattern length in channel bits
    logic raw;         // Bypass the run-length code
    logic last;        // Close the code after this NRZ byte
  } osf_sym_s;

  // One encoded group: left-aligned channel code and lengths
  typedef struct packed {
    logic [7:0] code;
    logic [3:0] clen;
    logic [2:0] nlen;
  } osf_grp_s;

  // One decoded group: hit flag, NRZ bit count, right-aligned bits
  typedef struct packed {
    logic hit;
    logic [2:0] nlen;
    logic [3:0] bits;
  } osf_dec_s;

  // Special channel patterns
  localparam logic [15:0] RESYNC_PAT = 16'h2024;
  localparam logic [15:0] ADDR_MARK_PAT = 16'h4804;
  localparam logic [39:0] SECTOR_MARK_PAT = 40'hC0FC0FFC12;
  localparam logic [39:0] SECTOR_MARK_MASK = 40'hFFFFFFFF7F;
  localparam int SECTOR_MARK_X_BIT = 7;
  localparam logic [4:0] RAW_FULL_LEN = 5'h10;
  localparam logic [4:0] RAW_HALF_LEN = 5'h08;

  // High-frequency 3T pattern, one word per start phase
  localparam logic [15:0] T3_PH0 = 16'h4924;
  localparam logic [15:0] T3_PH1 = 16'h9249;
  localparam logic [15:0] T3_PH2 = 16'h2492;

  // Header field lengths in bytes or chunks
  localparam int HDR_BYTES = 52;
  localparam int SECTOR_MARK_CHUNKS = 3;
  localparam int FIRST_VFO_BYTES = 12;
  localparam int SECOND_VFO_BYTES = 8;
  localparam int ID_BYTES = 5;
  localparam int ID_COPIES = 3;
  localparam int ID_COPY_LSB = 6;
  localparam logic [7:0] HDR_POSTAMBLE_VAL = 8'h00;

  // Data area field lengths
  localparam int DATA_VFO_BYTES = 12;
  localparam int SYNC_BYTES = 3;
  localparam int FLAG_BYTES = 5;
  localparam int USER_512 = 512;
  localparam int USER_1K = 1024;
  localparam int CP_BYTES = 12;
  localparam int RSV_512 = 2;
  localparam int RSV_1K = 0;
  localparam int CRC_BYTES = 4;
  localparam int ECC_512 = 80;
  localparam int ECC_1K = 160;
  localparam int RS_INT_512 = 15;
  localparam int RS_INT_1K = 20;
  localparam int RS_CNT_512 = 40;
  localparam int RS_CNT_1K = 59;
  localparam logic [7:0] RSV_VAL = 8'hFF;
  localparam logic [7:0] ECC_INV = 8'hFF;

  // ID CRC: x^16 + x^12 + x^5 + 1, preset ones, MSB first
  localparam logic [15:0] ID_CRC_POLY = 16'h1021;
  localparam logic [15:0] ID_CRC_INIT = 16'hFFFF;

  // One byte through the ID CRC, MSB first
  function automatic logic [15:0] osf_crc16(input logic [15:0] crc,
                                            input logic [7:0] b);
    logic [15:0] c;
    logic fb;
    c = crc;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ b[i];
      c = {c[14:0], 1'b0} ^ (fb ? ID_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction : osf_crc16

endpackage : osf_pkg

// ==== hw/osf_rll_enc.sv ====
// Serial (2,7) run-length encoder with raw pattern bypass
`timescale 1ns/1ps
module osf_rll_enc import osf_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire osf_sym_s sym_i,
  input wire logic sym_valid_i,
  output logic sym_ready_o,
  output logic chan_bit_o,
  output logic chan_valid_o,
  output logic idle_o
);

  // NRZ group to channel code
  function automatic osf_grp_s enc_group(input logic [3:0] b);
    osf_grp_s g;
    g = '{code: 8'h00, clen: 4'h4, nlen: 3'h2};
    casez (b)
      4'b10??: g = '{code: 8'h40, clen: 4'h4, nlen: 3'h2};
      4'b11??: g = '{code: 8'h80, clen: 4'h4, nlen: 3'h2};
      4'b000?: g = '{code: 8'h10, clen: 4'h6, nlen: 3'h3};
      4'b010?: g = '{code: 8'h90, clen: 4'h6, nlen: 3'h3};
      4'b011?: g = '{code: 8'h20, clen: 4'h6, nlen: 3'h3};
      4'b0010: g = '{code: 8'h24, clen: 4'h8, nlen: 3'h4};
      4'b0011: g = '{code: 8'h08, clen: 4'h8, nlen: 3'h4};
      default: g = '{code: 8'h00, clen: 4'h4, nlen: 3'h2};
    endcase
    return g;
  endfunction : enc_group

  logic [11:0] nrz_reg, nrz_next;
  logic [3:0] nrz_cnt_reg, nrz_cnt_next;
  logic flush_reg, flush_next;
  logic [15:0] out_reg, out_next;
  logic [4:0] out_cnt_reg, out_cnt_next;

  // Handshake and action decode
  wire osf_grp_s grp = enc_group(nrz_reg[11:8]); // [RULE7]
  wire out_busy = out_cnt_reg != 5'h00;
  wire flush_now = flush_reg || (sym_valid_i && sym_i.raw);
  wire do_enc = !out_busy && (nrz_cnt_reg >= 4'h4 ||
                (nrz_cnt_reg != 4'h0 && flush_now)); // [RULE11] [RULE15]
  wire take_raw = !out_busy && nrz_cnt_reg == 4'h0 && !flush_reg &&
                  sym_valid_i && sym_i.raw; // [RULE6]
  wire take_nrz = sym_valid_i && !sym_i.raw && nrz_cnt_reg < 4'h4 &&
                  !flush_reg && !do_enc;
  wire [11:0] byte_in = {sym_i.pat[7:0], 4'h0} >> nrz_cnt_reg;

  assign sym_ready_o = take_raw || take_nrz;
  assign chan_bit_o = out_reg[15];
  assign chan_valid_o = out_busy;
  assign idle_o = !out_busy && nrz_cnt_reg == 4'h0 && !flush_reg;

  // Next-state of NRZ buffer; short groups pad with zeros for closure
  always_comb begin
    nrz_next = nrz_reg;
    nrz_cnt_next = nrz_cnt_reg;
    flush_next = flush_reg;
    if (do_enc) begin
      nrz_next = nrz_reg << grp.nlen;
      nrz_cnt_next = (nrz_cnt_reg > 4'(grp.nlen)) ?
                     nrz_cnt_reg - 4'(grp.nlen) : 4'h0;
    end else if (take_nrz) begin
      nrz_next = nrz_reg | byte_in;
      nrz_cnt_next = nrz_cnt_reg + 4'h8;
      flush_next = sym_i.last;
    end else if (flush_reg && nrz_cnt_reg == 4'h0) begin
      flush_next = 1'b0;
    end
  end

  // Next-state of channel shifter
  always_comb begin
    out_next = out_reg;
    out_cnt_next = out_cnt_reg;
    if (do_enc) begin
      out_next = {grp.code, 8'h00};
      out_cnt_next = 5'(grp.clen);
    end else if (take_raw) begin
      out_next = sym_i.pat;
      out_cnt_next = sym_i.len;
    end else if (out_busy) begin
      out_next = {out_reg[14:0], 1'b0};
      out_cnt_next = out_cnt_reg - 5'h01;
    end
  end

  // State registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nrz_reg <= 12'h000;
      nrz_cnt_reg <= 4'h0;
      flush_reg <= 1'b0;
      out_reg <= 16'h0000;
      out_cnt_reg <= 5'h00;
    end else begin
      nrz_reg <= nrz_next;
      nrz_cnt_reg <= nrz_cnt_next;
      flush_reg <= flush_next;
      out_reg <= out_next;
      out_cnt_reg <= out_cnt_next;
    end
  end

endmodule : osf_rll_enc

// ==== sim/osf_chan_model.sv ====
// Read/write channel model: records written bits, replays them
`timescale 1ns/1ps
module osf_chan_model (
  input wire logic clk_i,
  input wire logic chan_bit_i,
  input wire logic chan_valid_i,
  output logic rx_bit_o,
  output logic rx_valid_o
);
  logic cap [0:32767];
  int n = 0;
  logic play = 1'b0;
  initial rx_bit_o = 1'b0;
  initial rx_valid_o = 1'b0;
  // Capture mid-cycle, away from the launching edge
  always @(negedge clk_i) if (chan_valid_i === 1'b1 && !play) begin
    cap[n] = chan_bit_i;
    n++;
  end
  // Idle read line keeps toggling so stale bits never match
  always @(posedge clk_i) if (!play) rx_bit_o <= ~rx_bit_o;
  // Replay the recorded bits, one per cycle
  task replay(input int cnt);
    play = 1'b1;
    for (int i = 0; i < cnt; i++) begin
      @(posedge clk_i) rx_bit_o <= cap[i];
      rx_valid_o <= 1'b1;
    end
    @(posedge clk_i) rx_valid_o <= 1'b0;
    play = 1'b0;
  endtask : replay
  // Forty recorded bits from a position, first bit in the MSB
  function automatic logic [39:0] grab(input int at);
    for (int i = 0; i < 40; i++) grab[39-i] = cap[at+i];
  endfunction : grab
  // Sixteen recorded bits from a position, first bit in the MSB
  function automatic logic [15:0] grab16(input int at);
    for (int i = 0; i < 16; i++) grab16[15-i] = cap[at+i];
  endfunction : grab16
endmodule : osf_chan_model

// ==== sim/osf_formatter_props.sv ====
// Port-level assertions for the sector formatter
`timescale 1ns/1ps
module osf_formatter_props import osf_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic hdr_start_i,
  input wire logic data_start_i,
  input wire logic rx_valid_i,
  input wire logic src_ready_o,
  input wire logic busy_o,
  input wire logic chan_bit_o,
  input wire logic chan_valid_o,
  input wire logic sector_mark_o,
  input wire logic id_found_o,
  input wire logic [15:0] id_track_o,
  input wire logic [1:0] id_copy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Activity only while busy: sequencer running or encoder still draining
  a_ready_in_busy: assert property (src_ready_o |-> busy_o)
    else $error("source byte taken while idle");
  a_chan_in_busy: assert property (chan_valid_o |-> busy_o)
    else $error("channel bit while idle");
  a_start_busy: assert property (
    !busy_o && (hdr_start_i || data_start_i) |=> busy_o)
    else $error("start not taken");
  // Header opens with the first mark bit two cycles on
  a_mark_first: assert property (
    !busy_o && hdr_start_i |-> ##2 (chan_valid_o && chan_bit_o))
    else $error("header did not open with mark bit");
  // Read side pulses
  a_mark_pulse: assert property (
    sector_mark_o |-> $past(rx_valid_i) ##1 !sector_mark_o)
    else $error("mark detect pulse wrong");
  a_id_pulse: assert property (id_found_o |=> !id_found_o)
    else $error("id found pulse too long");
  a_id_hold: assert property (
    !id_found_o |-> $stable(id_track_o) && $stable(id_copy_o))
    else $error("id fields changed without id found");
  a_copy_range: assert property (id_found_o |-> id_copy_o != 2'h3)
    else $error("illegal copy number");
endmodule : osf_formatter_props

bind osf_formatter osf_formatter_props u_props (.clk_i(clk_i),
  .rst_b_i(rst_b_i), .hdr_start_i(hdr_start_i),
  .data_start_i(data_start_i), .rx_valid_i(rx_valid_i),
  .src_ready_o(src_ready_o), .busy_o(busy_o), .chan_bit_o(chan_bit_o),
  .chan_valid_o(chan_valid_o), .sector_mark_o(sector_mark_o),
  .id_found_o(id_found_o), .id_track_o(id_track_o),
  .id_copy_o(id_copy_o));

// ==== sim/osf_formatter_tb.sv ====
// Self-checking bench for the sector formatter
`timescale 1ns/1ps
module osf_formatter_tb import osf_pkg::*;;
  logic clk_i = 1'b0, rst_b_i = 1'b0, hdr_start_i = 1'b0;
  logic data_start_i = 1'b0, size_1k_i = 1'b0, flag_en_i = 1'b0;
  logic src_valid_i = 1'b0, src_ready_o, busy_o, chan_bit_o, chan_valid_o;
  logic [15:0] hdr_track_i = 16'h0000;
  logic [5:0] hdr_sector_i = 6'h00;
  logic [7:0] src_data_i = 8'h00;
  logic rx_bit_i, rx_valid_i, sector_mark_o, id_found_o, id_crc_ok_o;
  logic [15:0] id_track_o;
  logic [5:0] id_sector_o;
  logic [1:0] id_copy_o;
  int err_count = 0, checks = 0, ids = 0, marks = 0;
  osf_formatter dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .hdr_start_i(hdr_start_i), .hdr_track_i(hdr_track_i),
    .hdr_sector_i(hdr_sector_i), .data_start_i(data_start_i),
    .size_1k_i(size_1k_i), .flag_en_i(flag_en_i), .src_data_i(src_data_i),
    .src_valid_i(src_valid_i), .src_ready_o(src_ready_o), .busy_o(busy_o),
    .chan_bit_o(chan_bit_o), .chan_valid_o(chan_valid_o),
    .rx_bit_i(rx_bit_i), .rx_valid_i(rx_valid_i),
    .sector_mark_o(sector_mark_o), .id_found_o(id_found_o),
    .id_track_o(id_track_o), .id_sector_o(id_sector_o),
    .id_copy_o(id_copy_o), .id_crc_ok_o(id_crc_ok_o));
  osf_chan_model chan (.clk_i(clk_i), .chan_bit_i(chan_bit_o),
    .chan_valid_i(chan_valid_o), .rx_bit_o(rx_bit_i),
    .rx_valid_o(rx_valid_i));
  always #5 clk_i = ~clk_i;
  // Verdict and end of run
  task stop_test;
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task expect_true(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      $display("CHECK FAILED %0t %s", $time, msg);
      err_count++;
    end
  endtask : expect_true
  task wait_idle(input int lim);
    int i;
    @(negedge clk_i);
    for (i = 0; i < lim && busy_o !== 1'b0; i++) @(negedge clk_i);
    if (i == lim) begin
      expect_true(1'b0, "timeout");
      stop_test();
    end
  endtask : wait_idle
  // Decoded ID fields from the read side
  always @(negedge clk_i) begin
    if (sector_mark_o === 1'b1) marks++;
    if (id_found_o === 1'b1) begin
      expect_true(id_track_o === 16'hA5C3 && id_sector_o === 6'h2B &&
        id_copy_o === ids[1:0] && id_crc_ok_o === 1'b1, "id");
      ids++;
    end
  end
  // Header write, then read back with the optional mark bit flipped
  task hdr_test;
    hdr_track_i <= 16'hA5C3;
    hdr_sector_i <= 6'h2B;
    chan.n = 0;
    @(posedge clk_i) hdr_start_i <= 1'b1;
    @(posedge clk_i) hdr_start_i <= 1'b0;
    wait_idle(5000);
    expect_true((chan.grab(0) & SECTOR_MARK_MASK) ===
      (SECTOR_MARK_PAT & SECTOR_MARK_MASK), "sector mark");
    expect_true(chan.grab16(40) === T3_PH0, "first vfo");
    expect_true(chan.grab16(232) === ADDR_MARK_PAT, "mark");
    chan.cap[32] = ~chan.cap[32];
    chan.replay(chan.n);
    repeat (4) @(negedge clk_i);
    expect_true(marks === 1, "sector mark detect");
    expect_true(ids === 3, "id copies");
  endtask : hdr_test
  // Data field write with a stream of source bytes
  task data_test(input logic big, input logic flag, input int exp);
    int n, base, rs;
    logic take;
    n = 0;
    chan.n = 0;
    size_1k_i <= big;
    flag_en_i <= flag;
    src_valid_i <= 1'b1;
    @(posedge clk_i) data_start_i <= 1'b1;
    @(posedge clk_i) data_start_i <= 1'b0;
    for (int i = 0; i < 60000 && (busy_o !== 1'b0 || i < 2); i++) begin
      @(negedge clk_i) take = (src_ready_o === 1'b1);
      if (take) n++;
      @(posedge clk_i) if (take) src_data_i <= src_data_i + 8'h01;
    end
    src_valid_i <= 1'b0;
    wait_idle(1);
    base = flag ? 80 : 0;
    expect_true(n === exp, "source byte count");
    expect_true(chan.grab16(0) === (flag ? T3_PH1 : T3_PH0),
      "field opening");
    expect_true(chan.grab16(base) === T3_PH0, "data vfo");
    expect_true(chan.grab(base + 192) === 40'h0000000000, "sync");
    expect_true(chan.grab16(chan.n - 16) === RESYNC_PAT,
      "postamble");
    // Resync pattern cannot arise in coded data, so count every hit
    rs = 0;
    for (int k = 0; k + 16 <= chan.n; k++)
      if (chan.grab16(k) === RESYNC_PAT) rs++;
    expect_true(rs === (big ? RS_CNT_1K : RS_CNT_512) + 1,
      "resync count");
  endtask : data_test
  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    hdr_test();
    data_test(1'b0, 1'b1, 608);
    data_test(1'b1, 1'b0, 1200);
    stop_test();
  end
endmodule : osf_formatter_tb
